// *** common/pcel_pkg.sv ***
// Notes on behaviour
// - Each status bit is set by its error event and cleared only by writing one to it.
// - Status and mask survive aresetn; only the power-on default initialises them.
// - A replay timer counts while a TLP is pending, clears on ack or nak, and sets bit 12 on expiry.
// - A 2-bit replay counter sets bit 8 each time it wraps.
// - Bad DLLP CRC, in-packet 8b/10b or disparity, or bad sequence sets bit 7.
// - Bad TLP CRC, 8b/10b or disparity in it, or bad sequence sets bit 6.
// - Any received 8b/10b symbol or framing error sets bit 0.
// - A mask bit of one stops the error message for that error.
// - There is one mask bit per implemented status bit, at bits 12, 8, 7, 6, 0.
// - A masked error is still logged in the status register.
package pcel_pkg;
  localparam logic [11:0] PCEL_OFS_STATUS = 12'h110;
  localparam logic [11:0] PCEL_OFS_MASK = 12'h114;
  localparam logic [11:0] PCEL_OFS_CAPCTL = 12'h118;
  localparam logic [11:0] PCEL_OFS_IRQ_MASK = 12'h130;
  localparam int PCEL_BIT_RPTO = 12;
  localparam int PCEL_BIT_RNUM = 8;
  localparam int PCEL_BIT_DLLP = 7;
  localparam int PCEL_BIT_TLP = 6;
  localparam int PCEL_BIT_RX = 0;
  localparam logic [31:0] PCEL_IMPL = 32'h0000_11c1;
  localparam logic [31:0] PCEL_RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] PCEL_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] PCEL_RST_CAPCTL = 32'h0000_0000;
  localparam int PCEL_CLK_MHZ = 50;
  localparam int PCEL_REPLAY_NS = 2000;
  localparam int PCEL_REPLAY_CYC = (PCEL_REPLAY_NS * PCEL_CLK_MHZ) / 1000;
  localparam logic [1:0] PCEL_RESP_OKAY = 2'b00;
  localparam logic [1:0] PCEL_RESP_SLVERR = 2'b10;
endpackage

// *** core/pcel_top.sv ***
`timescale 1ns/1ps
module pcel_top
  import pcel_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ack_nak_rx,
  input wire logic tlp_tx_pending,
  input wire logic replay_start,
  input wire logic dllp_crc_err,
  input wire logic dllp_code_err,
  input wire logic dllp_seq_err,
  input wire logic tlp_crc_err,
  input wire logic tlp_code_err,
  input wire logic tlp_seq_err,
  input wire logic rx_symbol_err,
  input wire logic rx_framing_err,
  output logic err_msg,
  output logic irq
);
  logic [31:0] status_r;
  logic [31:0] mask_r;
  logic [31:0] irq_mask_r;
  logic [31:0] events;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic [15:0] timer_r;
  logic [1:0] replay_cnt_r;
  logic rpto_evt;
  logic rnum_evt;
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_ok;

  // ==========================================================
  // Link event detection
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn || ack_nak_rx || !tlp_tx_pending)
      timer_r <= 16'h0000;
    else if (timer_r == 16'(PCEL_REPLAY_CYC - 1))
      timer_r <= 16'h0000;
    else
      timer_r <= timer_r + 16'h0001;
  end

  assign rpto_evt = tlp_tx_pending && !ack_nak_rx &&
                    (timer_r == 16'(PCEL_REPLAY_CYC - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || ack_nak_rx)
      replay_cnt_r <= 2'b00;
    else if (replay_start)
      replay_cnt_r <= replay_cnt_r + 2'b01;
  end

  assign rnum_evt = replay_start && !ack_nak_rx &&
                    (replay_cnt_r == 2'b11);

  always_comb
  begin
    events = 32'h0000_0000;
    events[PCEL_BIT_RPTO] = rpto_evt;
    events[PCEL_BIT_RNUM] = rnum_evt;
    events[PCEL_BIT_DLLP] = dllp_crc_err | dllp_code_err
                            | dllp_seq_err;
    events[PCEL_BIT_TLP] = tlp_crc_err | tlp_code_err | tlp_seq_err;
    events[PCEL_BIT_RX] = rx_symbol_err | rx_framing_err;
  end

  // ==========================================================
  // AXI4-Lite write path
  // ==========================================================
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_ok = (awaddr_r[11:2] == PCEL_OFS_STATUS[11:2]) ||
                 (awaddr_r[11:2] == PCEL_OFS_MASK[11:2]) ||
                 (awaddr_r[11:2] == PCEL_OFS_CAPCTL[11:2]) ||
                 (awaddr_r[11:2] == PCEL_OFS_IRQ_MASK[11:2]);
  always_comb
  begin
    wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
             {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
                      && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PCEL_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? PCEL_RESP_OKAY : PCEL_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // Sticky registers on power-on reset; interrupt mask on aresetn
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!por_n)
      status_r <= PCEL_RST_STATUS;
    else if (wr_go && awaddr_r[11:2] == PCEL_OFS_STATUS[11:2])
      status_r <= ((status_r & ~(wdata_r & wmask)) | events)
                  & PCEL_IMPL;
    else
      status_r <= (status_r | events) & PCEL_IMPL;
  end

  always_ff @(posedge aclk)
  begin
    if (!por_n)
      mask_r <= PCEL_RST_MASK;
    else if (wr_go && awaddr_r[11:2] == PCEL_OFS_MASK[11:2])
      mask_r <= ((mask_r & ~wmask) | (wdata_r & wmask))
                & PCEL_IMPL;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_r <= 32'h0000_0000;
    else if (wr_go && awaddr_r[11:2] == PCEL_OFS_IRQ_MASK[11:2])
      irq_mask_r <= ((irq_mask_r & ~wmask) | (wdata_r & wmask)) & PCEL_IMPL;
  end

  // ==========================================================
  // Error message and interrupt
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_msg <= 1'b0;
    else
      err_msg <= |(events & ~mask_r & PCEL_IMPL);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_r & irq_mask_r);
  end

  // ==========================================================
  // AXI4-Lite read path
  // ==========================================================
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr[11:2])
      PCEL_OFS_STATUS[11:2]: rd_val = status_r & PCEL_IMPL;
      PCEL_OFS_MASK[11:2]: rd_val = mask_r & PCEL_IMPL;
      PCEL_OFS_CAPCTL[11:2]: rd_val = PCEL_RST_CAPCTL;
      PCEL_OFS_IRQ_MASK[11:2]: rd_val = irq_mask_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PCEL_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= (s_axi_araddr[11:2] == PCEL_OFS_STATUS[11:2] ||
                        s_axi_araddr[11:2] == PCEL_OFS_MASK[11:2] ||
                        s_axi_araddr[11:2] == PCEL_OFS_CAPCTL[11:2] ||
                        s_axi_araddr[11:2] == PCEL_OFS_IRQ_MASK[11:2])
                       ? PCEL_RESP_OKAY : PCEL_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** tb/pcel_link.sv ***
`timescale 1ns/1ps
module pcel_link (
  input wire logic aclk,
  output logic dllp_crc_err,
  output logic dllp_code_err,
  output logic dllp_seq_err,
  output logic tlp_crc_err,
  output logic tlp_code_err,
  output logic tlp_seq_err,
  output logic rx_symbol_err,
  output logic rx_framing_err,
  output logic replay_start,
  output logic ack_nak_rx,
  output logic tlp_tx_pending
);
  logic [9:0] ev = '0;
  initial tlp_tx_pending = 1'b0;
  assign {ack_nak_rx, replay_start, rx_framing_err, rx_symbol_err} = ev[9:6];
  assign {tlp_seq_err, tlp_code_err, tlp_crc_err} = ev[5:3];
  assign {dllp_seq_err, dllp_code_err, dllp_crc_err} = ev[2:0];
  // One-cycle event: 0-7 errors, 8 retransmission, 9 ack or nak
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev <= '0;
  endtask
  task automatic pend(input logic v);
    @(posedge aclk);
    tlp_tx_pending <= v;
  endtask
endmodule

// *** tb/pcel_chk.sv ***
`timescale 1ns/1ps
module pcel_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_rd |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during bvalid");
  a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_wready)
    else $error("wready during bvalid");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  a_r_gap: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_arready)
    else $error("arready too early");
endmodule
bind pcel_top pcel_chk u_chk (.*);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import pcel_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, err_msg, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic ack_nak_rx, tlp_tx_pending, replay_start, dllp_crc_err, dllp_code_err;
  logic dllp_seq_err, tlp_crc_err, tlp_code_err, tlp_seq_err;
  logic rx_symbol_err, rx_framing_err;
  int num_errors = 0, n_compared = 0, seed = 61, st = 0, mk = 0;
  int bt[8] = '{7, 7, 7, 6, 6, 6, 0, 0};
  always #10 aclk = ~aclk;
  pcel_top u_dut (.*);
  pcel_link u_link (.*);
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw = 1'b0, w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
  endtask
  initial
  begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    rc(PCEL_OFS_STATUS, 0);
    rc(PCEL_OFS_CAPCTL, 0);
    wr(PCEL_OFS_MASK, '1);
    rc(PCEL_OFS_MASK, PCEL_IMPL);
    wr(12'h200, 32'h1);
    chk(r, PCEL_RESP_SLVERR);
    $display("registers done");
    for (int i = 0; i < 4; i++)
      u_link.pulse(8);
    #1;
    chk(err_msg, 0);
    st = 32'h100;
    rc(PCEL_OFS_STATUS, st);
    s_axi_wstrb <= 4'h1;
    wr(PCEL_OFS_STATUS, 32'h100);
    s_axi_wstrb <= 4'hf;
    rc(PCEL_OFS_STATUS, st);
    $display("replay count done");
    mk = $random(seed) & PCEL_IMPL;
    wr(PCEL_OFS_MASK, mk);
    for (int i = 0; i < 8; i++)
    begin
      u_link.pulse(i);
      #1;
      chk(err_msg, !mk[bt[i]]);
      st |= 1 << bt[i];
      rc(PCEL_OFS_STATUS, st);
      wr(PCEL_OFS_STATUS, 1 << bt[i]);
      st &= ~(1 << bt[i]);
      rc(PCEL_OFS_STATUS, st);
    end
    $display("events done");
    u_link.pend(1'b1);
    repeat (90) @(posedge aclk);
    u_link.pulse(9);
    repeat (90) @(posedge aclk);
    rc(PCEL_OFS_STATUS, st);
    repeat (20) @(posedge aclk);
    u_link.pend(1'b0);
    st |= 32'h1000;
    rc(PCEL_OFS_STATUS, st);
    wr(PCEL_OFS_IRQ_MASK, 32'h1000);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    wr(PCEL_OFS_STATUS, 32'h1000);
    st = st & ~32'h1000;
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    $display("timer and irq done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(PCEL_OFS_STATUS, st);
    rc(PCEL_OFS_MASK, mk);
    $display("reset done");
    print_verdict();
  end
endmodule
